// *** verilog/touch_panel_readout_ctrl.sv ***
// Touch panel readout: registers, touch sequencer and coordinate latches
// Functional notes
// - Control one bit 7 enables the touch function; resets to zero.
// - Three-bit sample field picks settling wait, 50us doubling up to 6.4ms.
// - After a touch event, sampling waits the settling time first.
// - Wake-up bit 3 with ADC enabled lets a touch leave sleep.
// - ADC clock is system clock divided by 4 doubling up to 512.
// - X high register shows X bits 9:2; reset zero.
// - Y high register shows Y bits 9:2; reset zero.
// - Low register holds X 1:0 in bits 1:0, Y 1:0 in 3:2.
// - Control two bit 7 selects manual sequencing; resets to zero.
// - Manual phase 00 keeps the ADC idle.
// - Manual phase 01 waits for touch; flags interrupt and status bit 3.
// - Manual phase 10 converts and latches X.
// - Manual phase 11 converts and latches Y.
module touch_panel_readout_ctrl #(
  parameter int SETTLE_BASE = touch_panel_pkg::SETTLE_BASE_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       touch_i,
  input  wire logic [9:0] sample_i,
  input  wire logic       sleep_i,
  output logic            sel_y_o,
  output logic            touch_irq_o,
  output logic            wake_o
);
  // Wider bases would overflow the settle counter at the longest code
  if (SETTLE_BASE < 1 || SETTLE_BASE > 2047) begin : g_bad_settle
    $error("SETTLE_BASE out of range");
  end

  typedef enum logic [2:0] {
    SEQ_IDLE   = 3'b000,
    SEQ_WAIT   = 3'b001,
    SEQ_SETTLE = 3'b010,
    SEQ_CONV   = 3'b011,
    SEQ_DONE   = 3'b100
  } seq_e;

  adc_link_if lnk ();

  // Panel inputs are asynchronous; two stages before use
  logic       touch_s1;
  logic       touch_s2;
  logic       sleep_s1;
  logic       sleep_s2;
  logic [9:0] sample_s1;
  logic [9:0] sample_s2;
  logic       next_touch_s1;
  logic       next_touch_s2;
  logic       next_sleep_s1;
  logic       next_sleep_s2;
  logic [9:0] next_sample_s1;
  logic [9:0] next_sample_s2;

  always_comb begin
    next_touch_s1  = touch_i;
    next_touch_s2  = touch_s1;
    next_sleep_s1  = sleep_i;
    next_sleep_s2  = sleep_s1;
    next_sample_s1 = sample_i;
    next_sample_s2 = sample_s1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      touch_s1  <= 1'b0;
      touch_s2  <= 1'b0;
      sleep_s1  <= 1'b0;
      sleep_s2  <= 1'b0;
      sample_s1 <= 10'h000;
      sample_s2 <= 10'h000;
    end else begin
      touch_s1  <= next_touch_s1;
      touch_s2  <= next_touch_s2;
      sleep_s1  <= next_sleep_s1;
      sleep_s2  <= next_sleep_s2;
      sample_s1 <= next_sample_s1;
      sample_s2 <= next_sample_s2;
    end
  end

  // Converter samples the synchronised bus, never the raw pins
  // Panel holds the sample steady through a conversion, so the stages settle first
  touch_adc_conv u_conv (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .sample_i  (sample_s2),
    .lnk       (lnk)
  );

  logic [7:0]  ctrl_one;
  logic        manual;
  logic [1:0]  phase;
  logic [9:0]  x_coord;
  logic [9:0]  y_coord;
  logic        event_flag;
  logic [7:0]  rdata;
  logic        irq;
  logic        wake;
  seq_e        state;
  logic        conv_y;
  logic [17:0] settle_cnt;
  logic        sel_y;

  logic [7:0]  next_ctrl_one;
  logic        next_manual;
  logic [1:0]  next_phase;
  logic [9:0]  next_x_coord;
  logic [9:0]  next_y_coord;
  logic        next_event_flag;
  logic [7:0]  next_rdata;
  logic        next_irq;
  logic        next_wake;
  seq_e        next_state;
  logic        next_conv_y;
  logic [17:0] next_settle_cnt;
  logic        next_sel_y;
  logic        start;
  logic        enable;
  logic        touch_seen;
  logic [17:0] settle_last;

  assign enable = ctrl_one[touch_panel_pkg::BIT_ENABLE];

  always_comb begin
    settle_last = 18'((SETTLE_BASE << ctrl_one[touch_panel_pkg::BIT_SAMPLE_HI:touch_panel_pkg::BIT_SAMPLE_LO]) - 1);
    touch_seen  = touch_s2;
    next_state      = state;
    next_conv_y     = conv_y;
    next_settle_cnt = settle_cnt;
    next_sel_y      = sel_y;
    next_x_coord    = x_coord;
    next_y_coord    = y_coord;
    next_irq        = 1'b0;
    next_wake       = 1'b0;
    start           = 1'b0;
    case (state)
      SEQ_IDLE: begin
        if (enable && !manual) begin
          next_state = SEQ_WAIT;
        end else if (enable && manual) begin
          case (phase)
            touch_panel_pkg::PHASE_WAIT: next_state = SEQ_WAIT;
            touch_panel_pkg::PHASE_LATCHX: begin
              next_conv_y     = 1'b0;
              next_settle_cnt = 18'h00000;
              next_state      = SEQ_SETTLE;
            end
            touch_panel_pkg::PHASE_LATCHY: begin
              next_conv_y     = 1'b1;
              next_settle_cnt = 18'h00000;
              next_state      = SEQ_SETTLE;
            end
            default: next_state = SEQ_IDLE;
          endcase
        end
      end
      SEQ_WAIT: begin
        if (manual && phase != touch_panel_pkg::PHASE_WAIT) begin
          next_state = SEQ_IDLE;
        end else if (touch_seen) begin
          next_irq        = 1'b1;
          next_wake       = sleep_s2 && ctrl_one[touch_panel_pkg::BIT_WAKE];
          next_conv_y     = 1'b0;
          next_settle_cnt = 18'h00000;
          next_state      = manual ? SEQ_DONE : SEQ_SETTLE;
        end
      end
      SEQ_SETTLE: begin
        next_sel_y = conv_y;
        if (settle_cnt == settle_last) begin
          start      = 1'b1;
          next_state = SEQ_CONV;
        end else begin
          next_settle_cnt = settle_cnt + 18'h00001;
        end
      end
      SEQ_CONV: begin
        if (lnk.done) begin
          // Whole coordinate in one register so high and low never mix
          if (conv_y) begin
            next_y_coord = lnk.data;
          end else begin
            next_x_coord = lnk.data;
          end
          if (!manual && !conv_y) begin
            next_conv_y     = 1'b1;
            next_settle_cnt = 18'h00000;
            next_state      = SEQ_SETTLE;
          end else begin
            next_state = SEQ_DONE;
          end
        end
      end
      SEQ_DONE: begin
        // Manual phases run once; write phase 00, then the phase again, to repeat
        if (!enable || (!manual && !touch_seen) || (manual && phase == touch_panel_pkg::PHASE_IDLE)) begin
          next_state = SEQ_IDLE;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
    // A conversion in SEQ_CONV finishes so its done pulse is caught; one started in the cycle enable drops loses it
    if (!enable && state != SEQ_CONV) begin
      next_state = SEQ_IDLE;
    end
  end

  assign lnk.start    = start;
  assign lnk.sel_y    = conv_y;
  assign lnk.div_code = ctrl_one[touch_panel_pkg::BIT_DIV_HI:touch_panel_pkg::BIT_DIV_LO];

  always_comb begin
    next_ctrl_one   = ctrl_one;
    next_manual     = manual;
    next_phase      = phase;
    next_event_flag = event_flag;
    next_rdata      = 8'h00;
    if (wr_i) begin
      case (addr_i)
        touch_panel_pkg::OFS_CONTROL_ONE: next_ctrl_one = wdata_i;
        touch_panel_pkg::OFS_CONTROL_TWO: begin
          next_manual = wdata_i[touch_panel_pkg::BIT_MANUAL];
          next_phase  = wdata_i[touch_panel_pkg::BIT_PHASE_HI:touch_panel_pkg::BIT_PHASE_LO];
        end
        touch_panel_pkg::OFS_STATUS: begin
          if (wdata_i[touch_panel_pkg::BIT_STAT_EVENT]) begin
            next_event_flag = 1'b0;
          end
        end
        default: next_event_flag = event_flag;
      endcase
    end
    // Set after clear so a same-cycle event is kept
    if (next_irq) begin
      next_event_flag = 1'b1;
    end
    if (rd_i) begin
      case (addr_i)
        touch_panel_pkg::OFS_CONTROL_ONE: next_rdata = ctrl_one;
        touch_panel_pkg::OFS_X_HIGH:      next_rdata = x_coord[9:2];
        touch_panel_pkg::OFS_Y_HIGH:      next_rdata = y_coord[9:2];
        touch_panel_pkg::OFS_XY_LOW:      next_rdata = {4'h0, y_coord[1:0], x_coord[1:0]};
        touch_panel_pkg::OFS_CONTROL_TWO: next_rdata = {manual, 5'h00, phase};
        touch_panel_pkg::OFS_STATUS:      next_rdata = {4'h0, event_flag, 3'h0};
        default:                          next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_one   <= touch_panel_pkg::RESET_CONTROL_ONE;
      manual     <= touch_panel_pkg::RESET_CONTROL_TWO[touch_panel_pkg::BIT_MANUAL];
      phase      <= touch_panel_pkg::RESET_CONTROL_TWO[touch_panel_pkg::BIT_PHASE_HI:touch_panel_pkg::BIT_PHASE_LO];
      event_flag <= 1'b0;
      rdata      <= 8'h00;
    end else begin
      ctrl_one   <= next_ctrl_one;
      manual     <= next_manual;
      phase      <= next_phase;
      event_flag <= next_event_flag;
      rdata      <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      x_coord    <= touch_panel_pkg::RESET_COORD;
      y_coord    <= touch_panel_pkg::RESET_COORD;
      irq        <= 1'b0;
      wake       <= 1'b0;
      state      <= SEQ_IDLE;
      conv_y     <= 1'b0;
      settle_cnt <= 18'h00000;
      sel_y      <= 1'b0;
    end else begin
      x_coord    <= next_x_coord;
      y_coord    <= next_y_coord;
      irq        <= next_irq;
      wake       <= next_wake;
      state      <= next_state;
      conv_y     <= next_conv_y;
      settle_cnt <= next_settle_cnt;
      sel_y      <= next_sel_y;
    end
  end

  assign rdata_o     = rdata;
  assign touch_irq_o = irq;
  assign wake_o      = wake;
  assign sel_y_o     = sel_y;
endmodule

// *** verilog/touch_panel_pkg.sv ***
// Constants and types shared by the touch panel readout block
package touch_panel_pkg;
  localparam logic [7:0] OFS_CONTROL_ONE = 8'hC0;
  localparam logic [7:0] OFS_X_HIGH      = 8'hC1;
  localparam logic [7:0] OFS_Y_HIGH      = 8'hC2;
  localparam logic [7:0] OFS_XY_LOW      = 8'hC3;
  localparam logic [7:0] OFS_CONTROL_TWO = 8'hC4;
  localparam logic [7:0] OFS_STATUS      = 8'h0F;

  localparam int BIT_ENABLE      = 7;
  localparam int BIT_SAMPLE_HI   = 6;
  localparam int BIT_SAMPLE_LO   = 4;
  localparam int BIT_WAKE        = 3;
  localparam int BIT_DIV_HI      = 2;
  localparam int BIT_DIV_LO      = 0;
  localparam int BIT_MANUAL      = 7;
  localparam int BIT_PHASE_HI    = 1;
  localparam int BIT_PHASE_LO    = 0;
  localparam int BIT_STAT_EVENT  = 3;

  localparam logic [7:0] RESET_CONTROL_ONE = 8'h00;
  localparam logic [7:0] RESET_CONTROL_TWO = 8'h00;
  localparam logic [9:0] RESET_COORD       = 10'h000;

  localparam int CLK_HZ           = 20_000_000;
  localparam int SETTLE_BASE_NS   = 50_000;
  localparam int SETTLE_BASE_CYC  = (SETTLE_BASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int ADC_DIV_BASE     = 4;
  localparam int ADC_CONV_TICKS   = 12;

  typedef enum logic [1:0] {
    PHASE_IDLE   = 2'b00,
    PHASE_WAIT   = 2'b01,
    PHASE_LATCHX = 2'b10,
    PHASE_LATCHY = 2'b11
  } phase_e;
endpackage

// *** verilog/adc_link_if.sv ***
// Request and result signals between the sequencer and the converter
interface adc_link_if;
  logic       start;
  logic       sel_y;
  logic [2:0] div_code;
  logic       done;
  logic [9:0] data;
  modport seq (output start, output sel_y, output div_code, input done, input data);
  modport conv (input start, input sel_y, input div_code, output done, output data);
endinterface

// *** verilog/touch_adc_conv.sv ***
// Converter pacing: divided ADC clock ticks and sample capture
module touch_adc_conv #(
  parameter int CONV_TICKS = touch_panel_pkg::ADC_CONV_TICKS
) (
  input  wire logic  clk_sys_i,
  input  wire logic  rst_n_i,
  input  wire logic [9:0] sample_i,
  adc_link_if.conv   lnk
);
  if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_bad_ticks
    $error("CONV_TICKS out of range");
  end

  logic [9:0] div_cnt;
  logic [7:0] tick_cnt;
  logic       busy;
  logic       done;
  logic [9:0] data;
  logic [9:0] next_div_cnt;
  logic [7:0] next_tick_cnt;
  logic       next_busy;
  logic       next_done;
  logic [9:0] next_data;
  logic [9:0] div_last;

  always_comb begin
    div_last      = 10'((touch_panel_pkg::ADC_DIV_BASE << lnk.div_code) - 1);
    next_div_cnt  = div_cnt;
    next_tick_cnt = tick_cnt;
    next_busy     = busy;
    next_done     = 1'b0;
    next_data     = data;
    if (!busy) begin
      if (lnk.start) begin
        next_busy     = 1'b1;
        next_div_cnt  = 10'h000;
        next_tick_cnt = 8'h00;
      end
    end else if (div_cnt == div_last) begin
      next_div_cnt = 10'h000;
      if (tick_cnt == 8'(CONV_TICKS - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_data = sample_i;
      end else begin
        next_tick_cnt = tick_cnt + 8'h01;
      end
    end else begin
      next_div_cnt = div_cnt + 10'h001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_cnt  <= 10'h000;
      tick_cnt <= 8'h00;
      busy     <= 1'b0;
      done     <= 1'b0;
      data     <= 10'h000;
    end else begin
      div_cnt  <= next_div_cnt;
      tick_cnt <= next_tick_cnt;
      busy     <= next_busy;
      done     <= next_done;
      data     <= next_data;
    end
  end

  assign lnk.done = done;
  assign lnk.data = data;
endmodule

// *** dv/touch_panel_sva.sv ***
// Port checker for the touch panel readout block
module touch_panel_sva (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       touch_i,
  input wire logic [9:0] sample_i,
  input wire logic       sleep_i,
  input wire logic       sel_y_o,
  input wire logic       touch_irq_o,
  input wire logic       wake_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] c1, c2, ra;
  logic [7:0] next_c1, next_c2, next_ra;
  logic       rv, next_rv;
  // Control shadows taken from the bus alone
  always_comb begin
    next_c1 = c1;
    next_c2 = c2;
    next_rv = rd_i;
    next_ra = addr_i;
    if (wr_i && addr_i == 8'hC0) next_c1 = wdata_i;
    if (wr_i && addr_i == 8'hC4) next_c2 = wdata_i;
    if (!rst_n_i) next_c1 = 8'h00;
    if (!rst_n_i) next_c2 = 8'h00;
  end
  always_ff @(posedge clk_sys_i) begin
    c1 <= next_c1;
    c2 <= next_c2;
    rv <= next_rv;
    ra <= next_ra;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_irq_one;
    touch_irq_o |=> !touch_irq_o;
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq too long");
  property p_wake_one;
    wake_o |=> !wake_o;
  endproperty
  a_wake_one: assert property (p_wake_one) else $error("wake too long");
  property p_irq_cause;
    touch_irq_o |-> $past(touch_i, 3) && c1[7];
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq no cause");
  property p_irq_phase;
    touch_irq_o |-> !c2[7] || c2[1:0] == 2'b01;
  endproperty
  a_irq_phase: assert property (p_irq_phase) else $error("irq bad phase");
  property p_wake_cause;
    wake_o |-> c1[7] && c1[3] && $past(sleep_i, 3) && $past(touch_i, 3);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake no cause");
  property p_low_rsv;
    rv && ra == 8'hC3 |-> rdata_o[7:4] == 4'h0;
  endproperty
  a_low_rsv: assert property (p_low_rsv) else $error("low byte top");
  property p_c1_read;
    rv && ra == 8'hC0 |-> rdata_o == c1;
  endproperty
  a_c1_read: assert property (p_c1_read) else $error("control one read");
  property p_c2_read;
    rv && ra == 8'hC4 |-> rdata_o == {c2[7], 5'h00, c2[1:0]};
  endproperty
  a_c2_read: assert property (p_c2_read) else $error("control two read");
  c_irq: cover property (touch_irq_o);
  c_wake: cover property (wake_o);
  c_y: cover property ($rose(sel_y_o));
endmodule
bind touch_panel_readout_ctrl touch_panel_sva chk_i (.clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .touch_i, .sample_i, .sleep_i, .sel_y_o, .touch_irq_o, .wake_o);

// *** dv/touch_panel_model.sv ***
// Resistive panel stand-in: touch level and axis sample
module touch_panel_model (
  input  wire logic       clk_sys_i,
  input  wire logic       press_i,
  input  wire logic       sel_y_i,
  input  wire logic [9:0] x_i,
  input  wire logic [9:0] y_i,
  output logic            touch_o,
  output logic [9:0]      sample_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign touch_o = press_i;
  initial sample_o = 10'h000;
  // Released panel floats, so the sample toggles rather than hold a stale value
  always @(posedge clk_sys_i) begin
    sample_o <= press_i ? (sel_y_i ? y_i : x_i) : ~sample_o;
  end
endmodule

// *** dv/test_touch_panel_readout_ctrl.sv ***
// Self-checking bench for the touch panel readout block
module test_touch_panel_readout_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SB = 4;
  logic       clk_sys_i = 0;
  logic       rst_n_i = 0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 0;
  logic       rd_i = 0;
  logic       sleep_i = 0;
  logic       press = 0;
  logic [9:0] x = 10'h000;
  logic [9:0] y = 10'h000;
  logic [7:0] rdata_o;
  logic [9:0] sample_i;
  logic       touch_i, sel_y_o, touch_irq_o, wake_o;
  int         err_count = 0;
  int         comparisons = 0;
  int         irq_n = 0;
  int         wake_n = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    irq_n += int'(touch_irq_o === 1'b1);
    wake_n += int'(wake_o === 1'b1);
  end
  touch_panel_readout_ctrl #(.SETTLE_BASE(SB)) dut (.clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .touch_i, .sample_i, .sleep_i, .sel_y_o, .touch_irq_o, .wake_o);
  touch_panel_model panel (.clk_sys_i, .press_i(press), .sel_y_i(sel_y_o), .x_i(x), .y_i(y),
    .touch_o(touch_i), .sample_o(sample_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] id);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: item %0h got %0h expected %0h", $time, id, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e, a);
  endtask
  task automatic t_reset;
    rd(8'hC0, 8'h00);
    rd(8'hC1, 8'h00);
    rd(8'hC2, 8'h00);
    rd(8'hC3, 8'h00);
    rd(8'hC4, 8'h00);
    rd(8'h50, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_regs;
    wr(8'hC0, 8'h7F);
    rd(8'hC0, 8'h7F);
    wr(8'hC4, 8'hFF);
    rd(8'hC4, 8'h83);
    wr(8'hC1, 8'h55);
    rd(8'hC1, 8'h00);
    wr(8'hC3, 8'hFF);
    rd(8'hC3, 8'h00);
    wr(8'hC4, 8'h00);
    wr(8'hC0, 8'h00);
    $display("register access done");
  endtask
  task automatic t_auto(input int s, input int d, input logic [9:0] xv, input logic [9:0] yv);
    int span;
    int n;
    span = (SB << s) + (4 << d) * touch_panel_pkg::ADC_CONV_TICKS;
    x <= xv;
    y <= yv;
    wr(8'hC0, {1'b1, s[2:0], 1'b0, d[2:0]});
    irq_n = 0;
    press <= 1'b1;
    for (n = 0; n < 10 && irq_n == 0; n++) cyc(1);
    chk(8'(irq_n), 8'h01, 8'hE1);
    for (n = 0; n < span + 10 && sel_y_o !== 1'b1; n++) cyc(1);
    // Settle plus X conversion before the axis swaps
    chk(8'(n >= span - 2 && n <= span + 6), 8'h01, 8'hE2);
    cyc(span + 10);
    rd(8'hC1, xv[9:2]);
    rd(8'hC2, yv[9:2]);
    rd(8'hC3, {4'h0, yv[1:0], xv[1:0]});
    press <= 1'b0;
    wr(8'hC0, 8'h00);
    cyc(5);
    $display("auto sequence done");
  endtask
  task automatic t_off;
    irq_n = 0;
    press <= 1'b1;
    cyc(20);
    chk(8'(irq_n), 8'h00, 8'hE3);
    press <= 1'b0;
    cyc(5);
    $display("disabled done");
  endtask
  task automatic t_manual;
    x <= 10'h1E4;
    y <= 10'h2C3;
    wr(8'hC0, 8'h80);
    wr(8'hC4, 8'h80);
    irq_n = 0;
    press <= 1'b1;
    cyc(20);
    chk(8'(irq_n), 8'h00, 8'hE4);
    rd(8'hC1, 8'h30);
    wr(8'hC4, 8'h81);
    cyc(6);
    chk(8'(irq_n), 8'h01, 8'hE5);
    rd(8'h0F, 8'h08);
    wr(8'h0F, 8'h08);
    rd(8'h0F, 8'h00);
    wr(8'hC4, 8'h80);
    wr(8'hC4, 8'h82);
    cyc(SB + 68);
    rd(8'hC1, 8'h79);
    rd(8'hC2, 8'hCF);
    rd(8'hC3, 8'h00);
    wr(8'hC4, 8'h80);
    wr(8'hC4, 8'h83);
    cyc(SB + 68);
    rd(8'hC2, 8'hB0);
    rd(8'hC3, 8'h0C);
    press <= 1'b0;
    wr(8'hC4, 8'h00);
    wr(8'hC0, 8'h00);
    $display("manual phases done");
  endtask
  task automatic t_wake(input logic [7:0] c, input logic [7:0] e);
    sleep_i <= 1'b1;
    wr(8'hC0, c);
    wake_n = 0;
    press <= 1'b1;
    cyc(8);
    chk(8'(wake_n), e, 8'hE6);
    cyc(2 * SB + 120);
    press <= 1'b0;
    wr(8'hC0, 8'h00);
    sleep_i <= 1'b0;
    cyc(5);
    $display("wake done");
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Longest case is the slowest auto run, near 0.7 ms
  initial begin
    #2_000_000;
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_regs;
    t_auto(0, 0, 10'h2A5, 10'h15A);
    t_auto(7, 7, 10'h0C3, 10'h33C);
    t_off;
    t_manual;
    t_wake(8'h80, 8'h00);
    t_wake(8'h88, 8'h01);
    print_verdict;
  end
endmodule
